// ### rfsc_pkg.sv
/*
 * Package for the RF control-word block: word layout, address codes,
 * field positions, reset values and output-selector codes.
 * Assumes nothing of its surroundings.
 */
package rfsc_pkg;

	localparam int WORD_W = 22;

	// word address codes, two lowest bits of each word
	localparam logic [1:0] ADDR_IF_REF = 2'h0;
	localparam logic [1:0] ADDR_IF_FB  = 2'h1;
	localparam logic [1:0] ADDR_RF_REF = 2'h2;
	localparam logic [1:0] ADDR_RF_FB  = 2'h3;

	// register-port map, word index into the plain port
	localparam logic [1:0] REG_LOAD   = 2'h0;
	localparam logic [1:0] REG_RF_REF = 2'h1;
	localparam logic [1:0] REG_RF_FB  = 2'h2;
	localparam logic [1:0] REG_STATUS = 2'h3;

	// reference word fields
	localparam int REF_DIV_LSB  = 2;
	localparam int REF_DIV_MSB  = 16;
	localparam int REF_POL_BIT  = 17;
	localparam int REF_GAIN_BIT = 18;
	localparam int REF_FLT_BIT  = 19;
	localparam int REF_SELA_BIT = 20;
	localparam int REF_SELB_BIT = 21;

	// feedback word fields
	localparam int FB_SWAL_LSB = 2;
	localparam int FB_SWAL_MSB = 8;
	localparam int FB_BIN_LSB  = 9;
	localparam int FB_BIN_MSB  = 19;
	localparam int FB_PRE_BIT  = 20;
	localparam int FB_PD_BIT   = 21;

	localparam logic [21:0] RF_REF_RESET = 22'h000002;
	localparam logic [21:0] RF_FB_RESET  = 22'h000003;
	localparam logic [1:0]  IF_SEL_RESET = 2'h0;

	// output-selector codes
	localparam logic [3:0] SEL_LOW      = 4'h0;
	localparam logic [3:0] SEL_IF_R     = 4'h1;
	localparam logic [3:0] SEL_RF_R     = 4'h2;
	localparam logic [3:0] SEL_FAST     = 4'h3;
	localparam logic [3:0] SEL_IF_LD    = 4'h4;
	localparam logic [3:0] SEL_IF_N     = 4'h5;
	localparam logic [3:0] SEL_RF_N     = 4'h6;
	localparam logic [3:0] SEL_RST_IF   = 4'h7;
	localparam logic [3:0] SEL_RF_LD    = 4'h8;
	localparam logic [3:0] SEL_IF_R2    = 4'h9;
	localparam logic [3:0] SEL_RF_R2    = 4'ha;
	localparam logic [3:0] SEL_RST_RF   = 4'hb;
	localparam logic [3:0] SEL_BOTH_LD  = 4'hc;
	localparam logic [3:0] SEL_IF_N2    = 4'hd;
	localparam logic [3:0] SEL_RF_N2    = 4'he;
	localparam logic [3:0] SEL_RST_ALL  = 4'hf;

	typedef enum logic [1:0] {
		PD_ACTIVE,
		PD_WAIT,
		PD_DOWN
	} rfsc_pd_type;

endpackage

// ### rfsc_sync.sv
/*
 * Two-flop synchroniser for a vector of asynchronous inputs.
 * Assumes the inputs come from outside i_clk's domain; the first stage is
 * read only by the second.
 */
`timescale 1ns/1ps
module rfsc_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_b,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] stage1;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_sync;

	always_comb begin
		next_stage1 = i_rst_b ? i_async : '0;
		next_sync   = i_rst_b ? stage1 : '0;
	end

	always_ff @(posedge i_clk) begin
		stage1 <= next_stage1;
		o_sync <= next_sync;
	end
endmodule

// ### rfsc_top.sv
/*
 * RF control-word decoder and multi-function output selector.
 * Software loads 22-bit words over a plain register port; the two lowest
 * bits route each word to the RF reference, RF feedback or IF reference
 * holding, or drop it (IF feedback). Divider, lock-detect and fast-acquire signals arrive from the
 * analog/divider core, asynchronous to i_clk.
 */
// How it works
// - address 10 loads reference, 11 feedback
// - bits 2-16 set reference divide ratio
// - bit 17 selects detector polarity
// - bit 18 selects pump gain
// - bit 19 floats pump immediately
// - float bit picks sync or async power-down
// - feedback bits 2-8 load swallow counter
// - feedback bits 9-19 load binary counter
// - feedback bit 20 selects prescaler modulus
// - feedback bit 21 powers down loop
// - selector gathered from RF and IF words
// - low, reference dividers, open-drain fast acquire
// - lock detect choices, push-pull
// - feedback divider choices, push-pull
// - counter-reset codes, pin driven low
// - address 00 carries IF selector bits
`timescale 1ns/1ps
module rfsc_top
	import rfsc_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic [1:0]  i_addr,
	input  wire logic [21:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic        i_pd_event,
	input  wire logic        i_if_ref_div,
	input  wire logic        i_rf_ref_div,
	input  wire logic        i_if_fb_div,
	input  wire logic        i_rf_fb_div,
	input  wire logic        i_if_lock,
	input  wire logic        i_rf_lock,
	input  wire logic        i_fast_acq,
	output logic [21:0]      o_rdata,
	output logic [14:0]      o_reference_divide_value,
	output logic             o_detector_polarity_select,
	output logic             o_pump_gain_select,
	output logic             o_pump_float_select,
	output logic [6:0]       o_swallow_count_value,
	output logic [10:0]      o_binary_count_value,
	output logic             o_prescaler_modulus_select,
	output logic             o_loop_power_down,
	output logic [3:0]       o_multi_function_output_select,
	output logic             o_mfo_out,
	output logic             o_mfo_oe_b,
	output logic             o_if_counter_reset,
	output logic             o_rf_counter_reset
);
	logic [21:0]  rf_ref;
	logic [21:0]  rf_fb;
	logic [1:0]   if_sel;
	logic [21:0]  next_rf_ref;
	logic [21:0]  next_rf_fb;
	logic [1:0]   next_if_sel;
	rfsc_pd_type  pd_state;
	rfsc_pd_type  next_pd_state;
	logic         pd_event_d;
	logic [21:0]  next_rdata;
	logic [7:0]   async_in;
	logic [7:0]   sync_in;
	logic         pd_event_s;
	logic [3:0]   sel;
	logic         next_mfo_out;
	logic         next_mfo_oe_b;
	logic         next_if_rst;
	logic         next_rf_rst;
	logic         load;

	assign async_in = {i_fast_acq, i_rf_lock, i_if_lock, i_rf_fb_div, i_if_fb_div,
		i_rf_ref_div, i_if_ref_div, i_pd_event};

	rfsc_sync #(
		.W(8)
	) u_sync (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_async (async_in),
		.o_sync  (sync_in)
	);

	assign pd_event_s = sync_in[0] & ~pd_event_d;
	assign load = i_wr && (i_addr == REG_LOAD);

	// word loading
	always_comb begin
		next_rf_ref = rf_ref;
		next_rf_fb  = rf_fb;
		next_if_sel = if_sel;
		if (load) begin
			case (i_wdata[1:0])
				ADDR_RF_REF: next_rf_ref = i_wdata;
				ADDR_RF_FB:  next_rf_fb  = i_wdata;
				ADDR_IF_REF: next_if_sel = {i_wdata[REF_SELA_BIT],
					i_wdata[REF_SELB_BIT]};
				default:     next_if_sel = if_sel;
			endcase
		end
		if (!i_rst_b) begin
			next_rf_ref = RF_REF_RESET;
			next_rf_fb  = RF_FB_RESET;
			next_if_sel = IF_SEL_RESET;
		end
	end

	always_ff @(posedge i_clk) begin
		rf_ref <= next_rf_ref;
		rf_fb  <= next_rf_fb;
		if_sel <= next_if_sel;
	end

	// power-down sequencing: floating pump means no wait for a safe instant
	always_comb begin
		next_pd_state = pd_state;
		case (pd_state)
			PD_ACTIVE: begin
				if (rf_fb[FB_PD_BIT]) begin
					if (rf_ref[REF_FLT_BIT])
						next_pd_state = PD_DOWN;
					else
						next_pd_state = PD_WAIT;
				end
			end
			PD_WAIT: begin
				if (!rf_fb[FB_PD_BIT])
					next_pd_state = PD_ACTIVE;
				else if (rf_ref[REF_FLT_BIT] || pd_event_s)
					next_pd_state = PD_DOWN;
			end
			PD_DOWN: begin
				if (!rf_fb[FB_PD_BIT])
					next_pd_state = PD_ACTIVE;
			end
			default: next_pd_state = PD_ACTIVE;
		endcase
		if (!i_rst_b)
			next_pd_state = PD_ACTIVE;
	end

	always_ff @(posedge i_clk) begin
		pd_state   <= next_pd_state;
		pd_event_d <= i_rst_b ? sync_in[0] : 1'b0;
	end

	// output selector
	assign sel = {rf_ref[REF_SELA_BIT], if_sel[1], rf_ref[REF_SELB_BIT], if_sel[0]};

	always_comb begin
		next_mfo_out  = 1'b0;
		next_mfo_oe_b = 1'b0;
		next_if_rst   = 1'b0;
		next_rf_rst   = 1'b0;
		case (sel)
			SEL_LOW:     next_mfo_out = 1'b0;
			SEL_IF_R, SEL_IF_R2: next_mfo_out = sync_in[1];
			SEL_RF_R, SEL_RF_R2: next_mfo_out = sync_in[2];
			SEL_FAST: begin
				// open drain: pull low only, release otherwise
				next_mfo_out  = 1'b0;
				next_mfo_oe_b = ~sync_in[7];
			end
			SEL_IF_LD:   next_mfo_out = sync_in[5];
			SEL_RF_LD:   next_mfo_out = sync_in[6];
			SEL_BOTH_LD: next_mfo_out = sync_in[5] & sync_in[6];
			SEL_IF_N, SEL_IF_N2: next_mfo_out = sync_in[3];
			SEL_RF_N, SEL_RF_N2: next_mfo_out = sync_in[4];
			SEL_RST_IF:  next_if_rst = 1'b1;
			SEL_RST_RF:  next_rf_rst = 1'b1;
			SEL_RST_ALL: begin
				next_if_rst = 1'b1;
				next_rf_rst = 1'b1;
			end
			default:     next_mfo_out = 1'b0;
		endcase
		if (!i_rst_b) begin
			next_mfo_out  = 1'b0;
			next_mfo_oe_b = 1'b0;
			next_if_rst   = 1'b0;
			next_rf_rst   = 1'b0;
		end
	end

	// read port: data valid the cycle after the strobe only
	always_comb begin
		next_rdata = '0;
		if (i_rd) begin
			case (i_addr)
				REG_RF_REF: next_rdata = rf_ref;
				REG_RF_FB:  next_rdata = rf_fb;
				REG_STATUS: next_rdata = {16'h0000, (pd_state == PD_DOWN),
					(pd_state == PD_WAIT), sel};
				default:    next_rdata = '0;
			endcase
		end
		if (!i_rst_b)
			next_rdata = '0;
	end

	always_ff @(posedge i_clk) begin
		o_rdata <= next_rdata;
		o_reference_divide_value <= rf_ref[REF_DIV_MSB:REF_DIV_LSB];
		o_detector_polarity_select <= rf_ref[REF_POL_BIT];
		o_pump_gain_select <= rf_ref[REF_GAIN_BIT];
		// float tracks the bit directly, not held for any divider edge
		o_pump_float_select <= rf_ref[REF_FLT_BIT];
		o_swallow_count_value <= rf_fb[FB_SWAL_MSB:FB_SWAL_LSB];
		o_binary_count_value <= rf_fb[FB_BIN_MSB:FB_BIN_LSB];
		o_prescaler_modulus_select <= rf_fb[FB_PRE_BIT];
		o_loop_power_down <= (next_pd_state == PD_DOWN);
		o_multi_function_output_select <= sel;
		o_mfo_out <= next_mfo_out;
		o_mfo_oe_b <= next_mfo_oe_b;
		o_if_counter_reset <= next_if_rst;
		o_rf_counter_reset <= next_rf_rst;
	end
endmodule

// ### rfsc_top_sva.sv
/* port checker for rfsc_top: field, selector, pin and power-down timing.
   assumes binding onto rfsc_top, one clock, synchronous active-low reset */
`timescale 1ns/1ps
module rfsc_top_sva
	import rfsc_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic [1:0]  i_addr,
	input  wire logic [21:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_pd_event,
	input  wire logic [14:0] o_reference_divide_value,
	input  wire logic        o_pump_float_select,
	input  wire logic [10:0] o_binary_count_value,
	input  wire logic        o_loop_power_down,
	input  wire logic [3:0]  o_multi_function_output_select,
	input  wire logic        o_mfo_out,
	input  wire logic        o_mfo_oe_b,
	input  wire logic        o_if_counter_reset,
	input  wire logic        o_rf_counter_reset
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	wire logic       ld  = i_wr && i_addr == REG_LOAD;
	wire logic [3:0] sel = o_multi_function_output_select;
	wire logic       pdw = ld && i_wdata[1:0] == ADDR_RF_FB && i_wdata[FB_PD_BIT];
	property p_ref;
		ld && i_wdata[1:0] == ADDR_RF_REF |-> ##2 o_reference_divide_value == $past(i_wdata[16:2], 2)
			&& o_pump_float_select == $past(i_wdata[19], 2);
	endproperty
	a_ref: assert property (p_ref) else $error("ref fields wrong");
	property p_sel;
		ld && i_wdata[1:0] == ADDR_RF_REF |-> ##2 {sel[3], sel[1]}
			== $past({i_wdata[REF_SELA_BIT], i_wdata[REF_SELB_BIT]}, 2);
	endproperty
	a_sel: assert property (p_sel) else $error("rf selector bits wrong");
	property p_ifsel;
		ld && i_wdata[1:0] == ADDR_IF_REF |-> ##2 {sel[2], sel[0]}
			== $past({i_wdata[REF_SELA_BIT], i_wdata[REF_SELB_BIT]}, 2);
	endproperty
	a_ifsel: assert property (p_ifsel) else $error("if selector bits wrong");
	property p_fb;
		ld && i_wdata[1:0] == ADDR_RF_FB |-> ##2 o_binary_count_value == $past(i_wdata[19:9], 2);
	endproperty
	a_fb: assert property (p_fb) else $error("binary count wrong");
	property p_rst;
		($stable(sel))[*2] |-> o_if_counter_reset == (sel == SEL_RST_IF || sel == SEL_RST_ALL)
			&& o_rf_counter_reset == (sel == SEL_RST_RF || sel == SEL_RST_ALL);
	endproperty
	a_rst: assert property (p_rst) else $error("counter reset wrong");
	property p_low;
		(sel == SEL_LOW || sel == SEL_RST_ALL)[*2] |-> !o_mfo_out && !o_mfo_oe_b;
	endproperty
	a_low: assert property (p_low) else $error("pin not driven low");
	property p_pdf;
		// float output one cycle on shows the float bit the sequencer decides with
		pdw ##1 o_pump_float_select |-> ##1 o_loop_power_down;
	endproperty
	a_pdf: assert property (p_pdf) else $error("late power-down");
	// float clear must wait: no detector edge may already sit in the sync pipe
	property p_pdw;
		(pdw && !i_pd_event && !$past(i_pd_event) && !$past(i_pd_event, 2))
			##1 (!o_pump_float_select && !o_loop_power_down) ##1 !o_pump_float_select
			|-> !o_loop_power_down ##1 !o_loop_power_down;
	endproperty
	a_pdw: assert property (p_pdw) else $error("early power-down");
endmodule
bind rfsc_top rfsc_top_sva u_sva (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_pd_event(i_pd_event),
	.o_reference_divide_value(o_reference_divide_value), .o_pump_float_select(o_pump_float_select),
	.o_binary_count_value(o_binary_count_value), .o_loop_power_down(o_loop_power_down),
	.o_multi_function_output_select(o_multi_function_output_select), .o_mfo_out(o_mfo_out),
	.o_mfo_oe_b(o_mfo_oe_b), .o_if_counter_reset(o_if_counter_reset),
	.o_rf_counter_reset(o_rf_counter_reset));

// ### rfsc_host.sv
/* host model: loads whole words and reads registers on the plain port.
   assumes the block's clock; read data sampled just after the answering edge */
`timescale 1ns/1ps
module rfsc_host (
	input  wire logic        i_clk,
	input  wire logic [21:0] i_rdata,
	output logic      [1:0]  o_addr,
	output logic      [21:0] o_wdata,
	output logic             o_wr,
	output logic             o_rd
);
	initial begin
		o_addr = 2'h0;
		o_wdata = 22'h0;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task automatic wr(input logic [21:0] w);
		// a real host never sends a ratio or binary count under 3
		if ((w[1:0] == 2'h2 && w[16:2] < 15'h3) || (w[1:0] == 2'h3 && w[19:9] < 11'h3)) return;
		@(posedge i_clk);
		o_addr <= 2'h0;
		o_wdata <= w;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [21:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		#1 d = i_rdata;
	endtask
endmodule

// ### tb_top.sv
/* testbench for rfsc_top: host model loads words, bench drives the divider,
   lock and detector inputs and checks fields, selector, pin and readback.
   assumes rfsc_host and the checker are compiled first */
`timescale 1ns/1ps
module tb_top;
	import rfsc_pkg::*;
	logic        clk, rst_b, wr, rd, pd_ev, pol, gain, flt, pre, pd, mfo, oe_b, ifr, rfr;
	logic [1:0]  addr;
	logic [3:0]  sel;
	logic [6:0]  an, swal;
	logic [10:0] bin;
	logic [14:0] rdiv;
	logic [21:0] wdata, rdata, w, d;
	int          num_errors, compares;
	rfsc_host h (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
	rfsc_top dut (.i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .i_pd_event(pd_ev), .i_if_ref_div(an[0]), .i_rf_ref_div(an[1]),
		.i_if_fb_div(an[2]), .i_rf_fb_div(an[3]), .i_if_lock(an[4]), .i_rf_lock(an[5]),
		.i_fast_acq(an[6]), .o_rdata(rdata), .o_reference_divide_value(rdiv),
		.o_detector_polarity_select(pol), .o_pump_gain_select(gain), .o_pump_float_select(flt),
		.o_swallow_count_value(swal), .o_binary_count_value(bin), .o_prescaler_modulus_select(pre),
		.o_loop_power_down(pd), .o_multi_function_output_select(sel), .o_mfo_out(mfo),
		.o_mfo_oe_b(oe_b), .o_if_counter_reset(ifr), .o_rf_counter_reset(rfr));
	task automatic chk(input string n, input logic [21:0] s, input logic [21:0] e);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// expected {pin level, active-low enable}; code 3 releases the pin unless pulling low
	function automatic logic [1:0] pin(input logic [3:0] c, input logic [6:0] a);
		case (c)
			4'h1, 4'h9: return {a[0], 1'b0};
			4'h2, 4'ha: return {a[1], 1'b0};
			4'h3: return {1'b0, ~a[6]};
			4'h4: return {a[4], 1'b0};
			4'h5, 4'hd: return {a[2], 1'b0};
			4'h6, 4'he: return {a[3], 1'b0};
			4'h8: return {a[5], 1'b0};
			4'hc: return {a[4] & a[5], 1'b0};
			default: return 2'h0;
		endcase
	endfunction
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		close_out();
	end
	initial begin
		rst_b = 1'b0;
		pd_ev = 1'b0;
		an = 7'h0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		settle(1);
		chk("reset sel", sel, 22'h0);
		for (int k = 0; k < 2; k++) begin
			w = k ? {5'h02, 15'h7fff, ADDR_RF_REF} : {5'h05, 15'h0003, ADDR_RF_REF};
			h.wr(w);
			settle(2);
			chk("ref div", rdiv, w[16:2]);
			chk("polarity", pol, w[17]);
			chk("gain", gain, w[18]);
			chk("float", flt, w[19]);
			h.rd(REG_RF_REF, d);
			chk("ref readback", d, w);
			w = k ? {2'h0, 11'h003, 7'h00, ADDR_RF_FB} : {2'h1, 11'h7ff, 7'h7f, ADDR_RF_FB};
			h.wr(w);
			settle(2);
			chk("fb fields", {pd, pre, bin, swal}, w[21:2]);
			h.rd(REG_RF_FB, d);
			chk("fb readback", d, w);
		end
		h.wr({20'hfffff, ADDR_IF_FB});
		settle(2);
		chk("ignored word div", rdiv, 22'h007fff);
		chk("ignored word bin", bin, 22'h000003);
		$display("fields test done");
		for (int c = 0; c < 48; c++) begin
			@(posedge clk);
			an <= (c < 16) ? 7'h25 : (c < 32) ? 7'h5a : 7'h7f;
			h.wr({c[1], c[3], 3'h0, 15'h0003, ADDR_RF_REF});
			h.wr({c[0], c[2], 18'h0, ADDR_IF_REF});
			settle(3);
			chk("selector", sel, c[3:0]);
			chk("pin", {mfo, oe_b}, pin(c[3:0], an));
			chk("counter reset", {ifr, rfr}, {c[3:0] == 7 || c[3:0] == 15,
				c[3:0] == 11 || c[3:0] == 15});
		end
		$display("selector test done");
		for (int k = 0; k < 2; k++) begin
			h.wr({1'b0, 1'b0, k == 0, 2'h0, 15'h0003, ADDR_RF_REF});
			settle(2);
			h.wr({2'h2, 11'h003, 7'h00, ADDR_RF_FB});
			settle(k ? 6 : 3);
			chk("power-down", pd, k == 0);
			h.rd(REG_STATUS, d);
			chk("status", d[5:4], k ? 2'h1 : 2'h2);
			if (k == 0) begin
				h.wr({2'h0, 11'h003, 7'h00, ADDR_RF_FB});
				settle(3);
				chk("power-up", pd, 1'b0);
			end
		end
		@(posedge clk);
		pd_ev <= 1'b1;
		for (int n = 0; n < 20 && pd !== 1'b1; n++)
			settle(1);
		chk("event power-down", pd, 1'b1);
		$display("power-down test done");
		@(posedge clk);
		rst_b <= 1'b0;
		pd_ev <= 1'b0;
		settle(1);
		chk("reset power-down", pd, 1'b0);
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		settle(1);
		chk("reset sel again", sel, 22'h0);
		chk("reset ref div", rdiv, RF_REF_RESET[REF_DIV_MSB:REF_DIV_LSB]);
		chk("reset stays up", pd, 1'b0);
		$display("reset test done");
		close_out();
	end
endmodule
